// *** design/fsf_top.sv ***
// Top module of the fault status flags block: live status, capture registers, AHB-Lite slave.
// Assumes a single AHB-Lite master, hclk at 100 MHz and conditions synchronous to hclk.
`timescale 1ns/1ps
`include "fsf_consts.svh"

// Summary of operation
// - Supply health bit 0 is high when supply rail overvoltage is detected.
// - Supply health bit 1 is low when the external reference is overloaded.
// - Supply health bit 2 is low when the internal reference lacks integrity.
// - Supply health bit 3 is low when the ground connection is open.
// - Supply health bit 4 is low on lockout or power management fault.
// - Supply health bit 5 is low on excessive switch reverse voltage.
// - Supply health bit 6 is AND of pulse, enable, load and reverse good.
// - Supply health bit 7 is low when current share is out of limits.
// - Power path bit 0 latches on overvoltage, undervoltage or overcurrent event.
// - Power path bit 1 is high while mains sense pulses are present.
// - Power path bit 2 is high once overcurrent timer is running.
// - Power path bits 3 to 7 show the five control pin states.
// - Monitor capture latches monitor flags, timeout, undervoltage and overvoltage faults.
// - Supply capture latches the eight supply health fault conditions.
// - Monitor status shows monitor pins, timeout, undervoltage and overvoltage faults.
module fsf_top (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Detector conditions.
  input wire fsf_pkg::fsf_monitor_s monitor_cond,
  input wire fsf_pkg::fsf_health_s health_cond,
  input wire fsf_pkg::fsf_path_s path_cond,
  // Interrupt.
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  fsf_pkg::fsf_byte_t monitor_status;
  fsf_pkg::fsf_byte_t supply_health_status;
  fsf_pkg::fsf_byte_t power_path_status;
  fsf_pkg::fsf_byte_t monitor_fault_capture;
  fsf_pkg::fsf_byte_t supply_health_capture;
  fsf_pkg::fsf_byte_t power_path_capture;
  fsf_pkg::fsf_byte_t next_supply_health;
  fsf_pkg::fsf_byte_t next_power_path;
  fsf_pkg::fsf_byte_t next_monitor;
  fsf_pkg::fsf_byte_t monitor_set;
  fsf_pkg::fsf_byte_t supply_set;
  fsf_pkg::fsf_byte_t power_set;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic [3:0] clear_pulse;
  logic fault_event;
  logic addr_ok;
  logic access;
  logic rd_access;
  logic [5:0] addr_idx;
  logic wr_pending;
  logic [5:0] wr_idx;
  logic [31:0] next_rdata;
  logic irq_read_clear;
  logic status_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  assign addr_idx = haddr[7:2];
  assign addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
  assign access = hsel && htrans[`FSF_HTRANS_NONSEQ_BIT] && hready;
  assign rd_access = access && !hwrite && addr_ok;
  assign irq_read_clear = rd_access && (addr_idx == `FSF_IDX_IRQ_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_idx <= 6'h00;
    end else begin
      wr_pending <= access && hwrite && addr_ok;
      wr_idx <= addr_idx;
    end
  end

  // Clear strobes; capture registers themselves take no write.
  always_comb begin
    clear_pulse = 4'h0;
    if (wr_pending && (wr_idx == `FSF_IDX_CAPTURE_CLEAR)) begin
      clear_pulse = hwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Live status words.

  always_comb begin
    next_monitor = {monitor_cond.ov_fault, monitor_cond.uv_fault, monitor_cond.ocp_timeout,
                    monitor_cond.monitor_pins};
    next_supply_health[0] = health_cond.supply_rail_overvoltage;
    next_supply_health[1] = health_cond.ext_ref_ok;
    next_supply_health[2] = health_cond.int_ref_ok;
    next_supply_health[3] = health_cond.gnd_ok;
    next_supply_health[4] = !(health_cond.below_supply_lockout_level ||
                              health_cond.power_mgmt_fault);
    next_supply_health[5] = health_cond.reverse_ok;
    next_supply_health[`FSF_SH_ORFET_BIT] = health_cond.pulse_present &&
      health_cond.power_enable_good && health_cond.load_voltage_good &&
      health_cond.reverse_ok;
    next_supply_health[7] = health_cond.share_ok;
  end

  assign fault_event = monitor_cond.ov_fault || monitor_cond.uv_fault ||
                       path_cond.ocp_event;

  always_comb begin
    next_power_path[`FSF_PP_FAULT_BIT] = fault_event ||
      (power_path_status[`FSF_PP_FAULT_BIT] && !clear_pulse[`FSF_CLR_FAULT_BIT]);
    next_power_path[1] = health_cond.pulse_present;
    next_power_path[`FSF_PP_OCP_BIT] = path_cond.ocp_timer_running;
    next_power_path[7:3] = {path_cond.mains_sense_pin, path_cond.power_on_request_pin,
                            path_cond.power_enable_pin, path_cond.power_on_link_pin,
                            path_cond.output_good_pin_state};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_status <= `FSF_RST_BYTE;
      supply_health_status <= `FSF_RST_BYTE;
      power_path_status <= `FSF_RST_BYTE;
    end else begin
      monitor_status <= next_monitor;
      supply_health_status <= next_supply_health;
      power_path_status <= next_power_path;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture registers.

  // Status words hold reset values until the first edge, so nothing is captured before then.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_valid <= 1'b0;
    end else begin
      status_valid <= 1'b1;
    end
  end

  // Fault conditions: high flags latch as they are, good flags latch when low.
  assign monitor_set = monitor_status & {8{status_valid}};
  assign supply_set = {~supply_health_status[7:1], supply_health_status[0]} &
                      {8{status_valid}};
  assign power_set = power_path_status & {8{status_valid}};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_capture
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          monitor_fault_capture[gi] <= 1'b0;
          supply_health_capture[gi] <= 1'b0;
          power_path_capture[gi] <= 1'b0;
        end else begin
          // Set wins over clear; the bit holds otherwise.
          monitor_fault_capture[gi] <= monitor_set[gi] ||
            (monitor_fault_capture[gi] && !clear_pulse[0]);
          supply_health_capture[gi] <= supply_set[gi] ||
            (supply_health_capture[gi] && !clear_pulse[1]);
          power_path_capture[gi] <= power_set[gi] ||
            (power_path_capture[gi] && !clear_pulse[2]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  assign irq_set[`FSF_IRQ_MONITOR_BIT] = |(monitor_set & ~monitor_fault_capture);
  assign irq_set[`FSF_IRQ_SUPPLY_BIT] = |(supply_set & ~supply_health_capture);
  assign irq_set[`FSF_IRQ_POWER_BIT] = |(power_set & ~power_path_capture);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= `FSF_RST_IRQ;
    end else begin
      irq_status <= irq_set | (irq_status & {3{!irq_read_clear}});
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `FSF_RST_IRQ;
    end else if (wr_pending && (wr_idx == `FSF_IDX_IRQ_MASK)) begin
      irq_mask <= hwdata[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and response.

  always_comb begin
    next_rdata = `FSF_RST_WORD;
    if (addr_ok) begin
      unique case (addr_idx)
        `FSF_IDX_MONITOR_STATUS: next_rdata = {24'h00_0000, monitor_status};
        `FSF_IDX_SUPPLY_HEALTH: next_rdata = {24'h00_0000, supply_health_status};
        `FSF_IDX_POWER_PATH: next_rdata = {24'h00_0000, power_path_status};
        `FSF_IDX_MONITOR_CAPTURE: next_rdata = {24'h00_0000, monitor_fault_capture};
        `FSF_IDX_SUPPLY_CAPTURE: next_rdata = {24'h00_0000, supply_health_capture};
        `FSF_IDX_POWER_CAPTURE: next_rdata = {24'h00_0000, power_path_capture};
        `FSF_IDX_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_status};
        `FSF_IDX_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
        default: next_rdata = `FSF_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `FSF_RST_WORD;
    end else if (access) begin
      hrdata <= hwrite ? `FSF_RST_WORD : next_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= `FSF_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `FSF_HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_supply_ov_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    health_cond.supply_rail_overvoltage |=> supply_health_status[0])
    else $error("supply overvoltage flag not set");

  a_ext_ref_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    !health_cond.ext_ref_ok |=> !supply_health_status[1] ##1 1'b1)
    else $error("external reference flag not low");

  a_supply_ok_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (health_cond.below_supply_lockout_level || health_cond.power_mgmt_fault)
    |=> !supply_health_status[4])
    else $error("supply good flag not low");

  a_switch_ok_and: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> supply_health_status[`FSF_SH_ORFET_BIT] ==
    $past(health_cond.pulse_present &&
    health_cond.power_enable_good && health_cond.load_voltage_good &&
    health_cond.reverse_ok))
    else $error("switch good flag is not the AND of its inputs");

  a_fault_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    fault_event ##1 (!clear_pulse[`FSF_CLR_FAULT_BIT])[*2]
    |-> power_path_status[`FSF_PP_FAULT_BIT] ##1 power_path_status[`FSF_PP_FAULT_BIT])
    else $error("fault latch lost without clear");

  a_pin_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> power_path_status[7:3] == $past({path_cond.mains_sense_pin,
    path_cond.power_on_request_pin, path_cond.power_enable_pin,
    path_cond.power_on_link_pin, path_cond.output_good_pin_state}))
    else $error("pin states not mirrored");

  a_monitor_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    monitor_cond.ov_fault |=> ##1 monitor_fault_capture[7])
    else $error("overvoltage not captured");

  a_capture_ro: assert property (@(posedge hclk) disable iff (!hresetn)
    (supply_health_capture != 8'h00) && !clear_pulse[1] |=> supply_health_capture != 8'h00)
    else $error("supply capture changed without clear");

  a_capture_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    power_path_capture[1] && !clear_pulse[2] |=> power_path_capture[1])
    else $error("capture bit dropped without clear");

  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt output does not follow masked status");

  a_int_ref_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    !health_cond.int_ref_ok |=> !supply_health_status[2])
    else $error("internal reference flag not low");

  a_ground_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    !health_cond.gnd_ok |=> !supply_health_status[3])
    else $error("ground flag not low");

  a_reverse_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    !health_cond.reverse_ok |=> !supply_health_status[5])
    else $error("reverse voltage flag not low");

  a_share_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    !health_cond.share_ok |=> !supply_health_status[7])
    else $error("current share flag not low");

  a_pulse_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> power_path_status[1] == $past(health_cond.pulse_present))
    else $error("pulse flag does not follow pulse presence");

  a_ocp_timer_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> power_path_status[`FSF_PP_OCP_BIT] == $past(path_cond.ocp_timer_running))
    else $error("overcurrent timer flag does not follow the timer");

  a_fault_latch_set: assert property (@(posedge hclk) disable iff (!hresetn)
    fault_event |=> power_path_status[`FSF_PP_FAULT_BIT])
    else $error("fault latch not set");

  a_fault_latch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clear_pulse[`FSF_CLR_FAULT_BIT] && !fault_event |=>
    !power_path_status[`FSF_PP_FAULT_BIT])
    else $error("fault latch not cleared");

  a_monitor_live: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> monitor_status == $past({monitor_cond.ov_fault, monitor_cond.uv_fault,
    monitor_cond.ocp_timeout, monitor_cond.monitor_pins}))
    else $error("monitor status word out of order");

  a_supply_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && !health_cond.share_ok |=> ##1 supply_health_capture[7])
    else $error("share fault not captured");

  a_power_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && path_cond.mains_sense_pin |=> ##1 power_path_capture[7])
    else $error("mains sense state not captured");

  a_no_reset_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    !status_valid |=> supply_health_capture == 8'h00)
    else $error("fault captured from reset values");

  a_capture_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clear_pulse[0] && (monitor_set == 8'h00) |=> monitor_fault_capture == 8'h00)
    else $error("monitor capture not cleared");

  a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pending && (wr_idx == `FSF_IDX_IRQ_MASK) |=> irq_mask == $past(hwdata[2:0]))
    else $error("interrupt mask not written");

  a_irq_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_read_clear && (irq_set == 3'h0) |=> irq_status == 3'h0)
    else $error("interrupt status not cleared by read");

  a_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_access && (addr_idx == `FSF_IDX_SUPPLY_HEALTH) |=>
    hrdata == {24'h00_0000, $past(supply_health_status)})
    else $error("read data does not match the register");

  a_write_data_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    access && hwrite |=> hrdata == `FSF_RST_WORD)
    else $error("read data not zero after a write");

endmodule

// *** design/fsf_consts.svh ***
// Register indices, field positions, reset values and bus codes of the fault status flags block.
// Assumes inclusion by the top module after the timescale directive.
`ifndef FSF_CONSTS_SVH
`define FSF_CONSTS_SVH

// Register indices; byte address is four times the index.
`define FSF_IDX_MONITOR_STATUS 6'h00
`define FSF_IDX_SUPPLY_HEALTH 6'h01
`define FSF_IDX_POWER_PATH 6'h02
`define FSF_IDX_MONITOR_CAPTURE 6'h2A
`define FSF_IDX_SUPPLY_CAPTURE 6'h2B
`define FSF_IDX_POWER_CAPTURE 6'h2C
`define FSF_IDX_IRQ_STATUS 6'h30
`define FSF_IDX_IRQ_MASK 6'h31
`define FSF_IDX_CAPTURE_CLEAR 6'h32

// Field positions.
`define FSF_SH_ORFET_BIT 6
`define FSF_PP_FAULT_BIT 0
`define FSF_PP_OCP_BIT 2
`define FSF_CLR_FAULT_BIT 3
`define FSF_IRQ_MONITOR_BIT 0
`define FSF_IRQ_SUPPLY_BIT 1
`define FSF_IRQ_POWER_BIT 2

// Reset values.
`define FSF_RST_BYTE 8'h00
`define FSF_RST_IRQ 3'h0
`define FSF_RST_WORD 32'h0000_0000

// AHB codes.
`define FSF_HTRANS_NONSEQ_BIT 1
`define FSF_HRESP_OKAY 1'h0

`endif

// *** design/fsf_pkg.sv ***
// Types shared by the fault status flags block.
// Assumes the condition signals are synchronous to hclk.
package fsf_pkg;

  typedef logic [7:0] fsf_byte_t;

  typedef struct packed {
    logic [4:0] monitor_pins;
    logic ocp_timeout;
    logic uv_fault;
    logic ov_fault;
  } fsf_monitor_s;

  typedef struct packed {
    logic supply_rail_overvoltage;
    logic ext_ref_ok;
    logic int_ref_ok;
    logic gnd_ok;
    logic below_supply_lockout_level;
    logic power_mgmt_fault;
    logic reverse_ok;
    logic pulse_present;
    logic power_enable_good;
    logic load_voltage_good;
    logic share_ok;
  } fsf_health_s;

  typedef struct packed {
    logic ocp_event;
    logic ocp_timer_running;
    logic output_good_pin_state;
    logic power_on_link_pin;
    logic power_enable_pin;
    logic power_on_request_pin;
    logic mains_sense_pin;
  } fsf_path_s;

endpackage

// *** verif/tb_top.sv ***
// Self-checking testbench of the fault status flags block.
// Assumes the block's header and package are compiled first and hready is fed from hreadyout.
`timescale 1ns/1ps
`include "fsf_consts.svh"

module tb_top;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, irq;
  fsf_pkg::fsf_monitor_s monitor_cond;
  fsf_pkg::fsf_health_s health_cond;
  fsf_pkg::fsf_path_s path_cond;
  int failures;
  int checks_done;
  // Healthy supply: every good flag high, no overvoltage, lockout or management fault.
  localparam logic [10:0] good = 11'h39F;
  localparam logic [5:0] i_ms = `FSF_IDX_MONITOR_STATUS;
  localparam logic [5:0] i_sh = `FSF_IDX_SUPPLY_HEALTH;
  localparam logic [5:0] i_pp = `FSF_IDX_POWER_PATH;
  localparam logic [5:0] i_mc = `FSF_IDX_MONITOR_CAPTURE;
  localparam logic [5:0] i_sc = `FSF_IDX_SUPPLY_CAPTURE;
  localparam logic [5:0] i_pc = `FSF_IDX_POWER_CAPTURE;
  localparam logic [5:0] i_is = `FSF_IDX_IRQ_STATUS;
  localparam logic [5:0] i_im = `FSF_IDX_IRQ_MASK;
  localparam logic [5:0] i_cc = `FSF_IDX_CAPTURE_CLEAR;

  fsf_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .monitor_cond(monitor_cond),
    .health_cond(health_cond), .path_cond(path_cond), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for hready sampled high, giving up after a bounded number of edges.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(hresp, `FSF_HRESP_OKAY);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, {24'h000000, idx, 2'b00}, 32'h0000_0000, d);
    check(d, exp);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, {24'h000000, idx, 2'b00}, wd, d);
  endtask

  // Applies a set of conditions, then lets status, capture and interrupt settle.
  task automatic set_cond(input logic [7:0] m, input logic [10:0] h, input logic [6:0] p);
    @(posedge hclk);
    monitor_cond <= m;
    health_cond <= h;
    path_cond <= p;
    repeat (4) @(posedge hclk);
  endtask

  function automatic logic [7:0] exp_sh(input fsf_pkg::fsf_health_s h);
    exp_sh = {h.share_ok,
              h.pulse_present & h.power_enable_good & h.load_voltage_good & h.reverse_ok,
              h.reverse_ok, ~(h.below_supply_lockout_level | h.power_mgmt_fault),
              h.gnd_ok, h.int_ref_ok, h.ext_ref_ok, h.supply_rail_overvoltage};
  endfunction

  // Pulses stay present throughout, so bit 1 is high.
  function automatic logic [7:0] exp_pp(input fsf_pkg::fsf_path_s p, input logic f);
    exp_pp = {p.mains_sense_pin, p.power_on_request_pin, p.power_enable_pin,
              p.power_on_link_pin, p.output_good_pin_state, p.ocp_timer_running, 1'b1, f};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_baseline();
    rd_chk(i_sh, 32'h0000_00FE);
    rd_chk(i_pp, 32'h0000_0002);
    rd_chk(i_pc, 32'h0000_0002);
    rd_chk(i_sc, 32'h0000_0000);
    rd_chk(i_mc, 32'h0000_0000);
    wr(i_cc, 32'h0000_0004);
    rd_chk(i_pc, 32'h0000_0002);
  endtask

  task automatic t_supply();
    logic [10:0] h;
    for (int i = 0; i < 11; i++) begin
      h = good ^ (11'h001 << i);
      set_cond(8'h00, h, 7'h00);
      rd_chk(i_sh, {24'h000000, exp_sh(h)});
    end
    set_cond(8'h00, good, 7'h00);
    rd_chk(i_sc, 32'h0000_00FF);
    wr(i_sc, 32'h0000_0000);
    rd_chk(i_sc, 32'h0000_00FF);
    wr(i_cc, 32'h0000_0002);
    rd_chk(i_sc, 32'h0000_0000);
  endtask

  task automatic t_path();
    logic [6:0] p;
    for (int i = 0; i < 6; i++) begin
      p = 7'h01 << i;
      set_cond(8'h00, good, p);
      rd_chk(i_pp, {24'h000000, exp_pp(p, 1'b0)});
    end
    set_cond(8'h00, good, 7'h40);
    set_cond(8'h00, good, 7'h00);
    rd_chk(i_pp, 32'h0000_0003);
    wr(i_pp, 32'h0000_00FF);
    rd_chk(i_pp, 32'h0000_0003);
    rd_chk(i_pc, 32'h0000_00FF);
    wr(i_cc, 32'h0000_0008);
    wr(i_cc, 32'h0000_0004);
    rd_chk(i_pp, 32'h0000_0002);
    rd_chk(i_pc, 32'h0000_0002);
  endtask

  task automatic t_monitor();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      set_cond(m, good, 7'h00);
      rd_chk(i_ms, {24'h000000, m[0], m[1], m[2], m[7:3]});
    end
    set_cond(8'h00, good, 7'h00);
    rd_chk(i_mc, 32'h0000_00FF);
    rd_chk(i_pp, 32'h0000_0003);
    wr(i_mc, 32'h0000_0000);
    rd_chk(i_mc, 32'h0000_00FF);
    wr(i_cc, 32'h0000_0009);
    rd_chk(i_mc, 32'h0000_0000);
    rd_chk(i_pp, 32'h0000_0002);
  endtask

  task automatic t_irq();
    logic [31:0] d;
    rd_chk(i_im, 32'h0000_0000);
    xfer(1'b0, {24'h000000, i_is, 2'b00}, 32'h0000_0000, d);
    set_cond(8'h04, good, 7'h00);
    set_cond(8'h00, good, 7'h00);
    check(irq, 1'b0);
    rd_chk(i_is, 32'h0000_0001);
    rd_chk(i_is, 32'h0000_0000);
    wr(i_im, 32'h0000_0007);
    rd_chk(i_im, 32'h0000_0007);
    wr(i_cc, 32'h0000_0001);
    set_cond(8'h04, good, 7'h00);
    check(irq, 1'b1);
    set_cond(8'h00, good, 7'h00);
    rd_chk(i_is, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    wr(6'h3F, 32'h0000_00FF);
    rd_chk(6'h3F, 32'h0000_0000);
    xfer(1'b0, 32'h0000_0100, 32'h0000_0000, d);
    check(d, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    monitor_cond = 8'h00;
    health_cond = good;
    path_cond = 7'h00;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_baseline();
    t_supply();
    t_path();
    t_monitor();
    t_irq();
    print_verdict();
  end
endmodule
